// File: verilog/wpm_regs.svh
// Register offsets, bit positions, reset values and timing counts of the
// watchdog and power mode controller. Included by the wpm_ctrl module only.
`ifndef WPM_REGS_SVH
`define WPM_REGS_SVH

// ----------------------------------------
// Register addresses (special function space)
// ----------------------------------------
`define WPM_ADDR_PWR_CTRL 8'h87
`define WPM_ADDR_STANDBY_SELECT_CTRL 8'h92
`define WPM_ADDR_WD_CTRL 8'heb
`define WPM_ADDR_WD_RELOAD 8'hff

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WPM_PC_IDLE 0
`define WPM_PC_PDOWN 1
`define WPM_PC_GF0 2
`define WPM_PC_GF1 3
`define WPM_PC_WLE 4
`define WPM_SC_STANDBY_SELECT 0
`define WPM_WC_BUSY 0
`define WPM_WC_EW 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define WPM_RST_PWR_CTRL 8'h00
`define WPM_RST_STANDBY_SELECT_CTRL 8'h00
`define WPM_RST_WD_CTRL 8'h00
`define WPM_RST_WD_RELOAD 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define WPM_CLK_HZ 100000000
`define WPM_TICK_MS 2
`define WPM_TICK_CYC (`WPM_CLK_HZ / 1000 * `WPM_TICK_MS)
`define WPM_OSC_START_CYC 2048
`define WPM_RST_HOLD_CYC 2
`define WPM_WD_RST_CYC 24
`define WPM_ANA_SETTLE_US 10
`define WPM_ANA_SETTLE_CYC (`WPM_CLK_HZ / 1000000 * `WPM_ANA_SETTLE_US)

`endif

// File: verilog/wpm_pkg.sv
// Types shared by the watchdog and power mode controller.
// Assumes wpm_regs.svh is on the include path.
package wpm_pkg;

	// ----------------------------------------
	// Power sequencing states
	// ----------------------------------------
	typedef enum logic [3:0] {
		WPM_RUN   = 4'b0001,
		WPM_IDLE  = 4'b0010,
		WPM_PDOWN = 4'b0100,
		WPM_WAKE  = 4'b1000
	} wpm_mode_t;

	// ----------------------------------------
	// Register access from the CPU core
	// ----------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} wpm_sfr_req_t;

	// Clock gating and domain enables toward the rest of the chip
	typedef struct packed {
		logic cpu_clk_en;
		logic periph_clk_en;
		logic osc_run;
		logic analog_en;
		logic analog_ready;
	} wpm_gate_t;

endpackage

// File: verilog/wpm_tick_div.sv
// Prescaler that turns the system clock into the watchdog period tick.
// Assumes clk_i is the always-running system clock.
module wpm_tick_div import wpm_pkg::*; #(
	parameter int unsigned DIV = 200000
) (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic run_i, // Count while high, clear while low
	output logic tick_o // One-cycle pulse every DIV cycles
);

	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} wpm_div_state_t;

	wpm_div_state_t st, next_st;

	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (!run_i) begin
			next_st.cnt = '0;
		end else if (st.cnt == DIV - 1) begin
			next_st.cnt = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 32'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick_o = st.tick;

endmodule

// File: verilog/wpm_ctrl.sv
// Watchdog timer and reduced power mode controller of the microcontroller.
// Assumes the CPU core issues one register access per cycle on the sfr port,
// and that the core owns the interrupt enables and level-sense choice.

// Macros are needed by the parameter defaults, so the header comes first
`include "wpm_regs.svh"

module wpm_ctrl import wpm_pkg::*; #(
	parameter int unsigned TICK_CYC = `WPM_TICK_CYC, // Cycles per watchdog tick
	parameter int unsigned OSC_START_CYC = `WPM_OSC_START_CYC // Wake delay
) (
	input wire logic clk_i, // System clock, 100 MHz
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic ext_reset_i, // External reset pin level, active high
	input wire wpm_sfr_req_t sfr_i, // Register access from the CPU core
	output logic [7:0] sfr_rdata_o, // Read data, registered, valid in the cycle after rd
	output logic sfr_hit_o, // Address belongs to this block
	input wire logic irq_pending_i, // Any enabled interrupt asserted
	input wire logic wake_irq_i, // Enabled level-sensitive external interrupt
	output wpm_gate_t gate_o, // Clock and domain enables
	output logic chip_reset_o, // Device-wide reset request
	output logic [7:0] wd_count_o // Watchdog counter value
);

	localparam int unsigned WD_RST_CYC = `WPM_WD_RST_CYC;
	localparam int unsigned ANA_CYC = `WPM_ANA_SETTLE_CYC;

	typedef struct packed {
		wpm_mode_t mode;
		logic [7:0] wd_cnt;
		logic [7:0] wd_reload;
		logic load_en;
		logic gf1;
		logic gf0;
		logic wd_en;
		logic busy_flag;
		logic standby_select;
		logic [1:0] rst_hold;
		logic [11:0] wake_cnt;
		logic [4:0] wd_rst_cnt;
		logic [10:0] ana_cnt;
		logic [7:0] rdata;
	} wpm_state_t;

	wpm_state_t st, next_st;
	logic tick;
	logic wr_pc, wr_sc, wr_wc, wr_wd;
	logic held_reset;
	logic [7:0] pc_view;

	// ----------------------------------------
	// Watchdog tick prescaler
	// ----------------------------------------
	// Divider is held clear while the watchdog is off so intervals start whole
	wpm_tick_div #(
		.DIV(TICK_CYC)
	) u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(st.wd_en && st.mode != WPM_PDOWN),
		.tick_o(tick)
	);

	function automatic logic is_addr(input wpm_sfr_req_t r, input logic [7:0] a);
		return r.addr == a;
	endfunction

	assign wr_pc = sfr_i.wr && is_addr(sfr_i, `WPM_ADDR_PWR_CTRL);
	assign wr_sc = sfr_i.wr && is_addr(sfr_i, `WPM_ADDR_STANDBY_SELECT_CTRL);
	assign wr_wc = sfr_i.wr && is_addr(sfr_i, `WPM_ADDR_WD_CTRL);
	assign wr_wd = sfr_i.wr && is_addr(sfr_i, `WPM_ADDR_WD_RELOAD);

	// Reset pin must be seen for two consecutive cycles before it acts
	assign held_reset = ext_reset_i && st.rst_hold == 2'(`WPM_RST_HOLD_CYC - 1);

	always_comb begin
		pc_view = 8'h00;
		pc_view[`WPM_PC_WLE] = st.load_en;
		pc_view[`WPM_PC_GF1] = st.gf1;
		pc_view[`WPM_PC_GF0] = st.gf0;
		pc_view[`WPM_PC_PDOWN] = st.mode == WPM_PDOWN || st.mode == WPM_WAKE;
		pc_view[`WPM_PC_IDLE] = st.mode == WPM_IDLE;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.rdata = 8'h00;

		// Pin filter counts only while the pin stays high
		if (ext_reset_i && st.rst_hold != 2'(`WPM_RST_HOLD_CYC - 1)) begin
			next_st.rst_hold = st.rst_hold + 2'h1;
		end else if (!ext_reset_i) begin
			next_st.rst_hold = 2'h0;
		end

		// Register reads; reserved bits read as zero
		if (sfr_i.rd) begin
			unique case (sfr_i.addr)
				`WPM_ADDR_PWR_CTRL: next_st.rdata = pc_view;
				`WPM_ADDR_STANDBY_SELECT_CTRL: next_st.rdata = {7'h00, st.standby_select};
				`WPM_ADDR_WD_CTRL: next_st.rdata = {6'h00, st.wd_en, st.busy_flag};
				`WPM_ADDR_WD_RELOAD: next_st.rdata = st.wd_reload;
				default: next_st.rdata = 8'h00;
			endcase
		end

		// Watchdog counting keeps going in run and idle
		if (st.wd_en && tick) begin
			next_st.wd_cnt = st.wd_cnt + 8'h01;
			if (st.wd_cnt == 8'hff) begin
				next_st.wd_rst_cnt = 5'(WD_RST_CYC);
			end
		end

		// Standby control and analog settle timer
		if (wr_sc) begin
			next_st.standby_select = sfr_i.wdata[`WPM_SC_STANDBY_SELECT];
			if (st.standby_select && !sfr_i.wdata[`WPM_SC_STANDBY_SELECT]) begin
				next_st.ana_cnt = 11'(ANA_CYC);
			end
		end else if (st.ana_cnt != 11'h0) begin
			next_st.ana_cnt = st.ana_cnt - 11'h1;
		end

		if (wr_wc) begin
			next_st.wd_en = sfr_i.wdata[`WPM_WC_EW];
			next_st.busy_flag = sfr_i.wdata[`WPM_WC_BUSY];
		end

		// Reload: write loads only with load-enable already set
		if (wr_wd) begin
			next_st.wd_reload = sfr_i.wdata;
			if (st.load_en) begin
				next_st.wd_cnt = sfr_i.wdata;
				next_st.load_en = 1'b0;
			end
		end

		// Power control writes and sequencing
		unique case (st.mode)
			WPM_RUN: begin
				if (wr_pc) begin
					next_st.gf1 = sfr_i.wdata[`WPM_PC_GF1];
					next_st.gf0 = sfr_i.wdata[`WPM_PC_GF0];
					if (!(wr_wd && st.load_en)) begin
						next_st.load_en = sfr_i.wdata[`WPM_PC_WLE];
					end
					if (sfr_i.wdata[`WPM_PC_PDOWN] && !st.wd_en) begin
						next_st.mode = WPM_PDOWN;
					end else if (sfr_i.wdata[`WPM_PC_IDLE]) begin
						next_st.mode = WPM_IDLE;
					end
				end
			end
			WPM_IDLE: begin
				if (irq_pending_i) begin
					next_st.mode = WPM_RUN;
				end
			end
			WPM_PDOWN: begin
				if (wake_irq_i) begin
					next_st.mode = WPM_WAKE;
					next_st.wake_cnt = 12'(OSC_START_CYC);
				end
			end
			WPM_WAKE: begin
				if (st.wake_cnt == 12'h1) begin
					next_st.mode = WPM_RUN;
				end
				next_st.wake_cnt = st.wake_cnt - 12'h1;
			end
		endcase

		if (st.wd_rst_cnt != 5'h0) begin
			next_st.wd_rst_cnt = st.wd_rst_cnt - 5'h1;
		end

		// Held reset pin reinitialises registers; RAM lies outside this block
		if (held_reset) begin
			next_st = '0;
			next_st.mode = WPM_RUN;
			next_st.rst_hold = st.rst_hold;
			if (st.mode == WPM_PDOWN || st.mode == WPM_WAKE) begin
				next_st.mode = WPM_WAKE;
				next_st.wake_cnt = 12'(OSC_START_CYC);
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i || (st.wd_rst_cnt == 5'h1)) begin
			st <= '0;
			st.mode <= WPM_RUN;
			st.wd_reload <= `WPM_RST_WD_RELOAD;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Register contents are simply held in power-down; in idle the watchdog counter keeps counting
	always_comb begin
		gate_o.cpu_clk_en = st.mode == WPM_RUN;
		gate_o.periph_clk_en = st.mode == WPM_RUN || st.mode == WPM_IDLE;
		gate_o.osc_run = st.mode != WPM_PDOWN;
		gate_o.analog_en = !st.standby_select;
		gate_o.analog_ready = !st.standby_select && st.ana_cnt == 11'h0;
	end

	assign chip_reset_o = st.wd_rst_cnt != 5'h0 || held_reset;
	assign sfr_rdata_o = st.rdata;
	assign sfr_hit_o = sfr_i.addr == `WPM_ADDR_PWR_CTRL || sfr_i.addr == `WPM_ADDR_STANDBY_SELECT_CTRL
		|| sfr_i.addr == `WPM_ADDR_WD_CTRL || sfr_i.addr == `WPM_ADDR_WD_RELOAD;
	assign wd_count_o = st.wd_cnt;

endmodule

// File: tb/wpm_ctrl_properties.sv
// Port checker of the watchdog and power mode controller.
// Bound into wpm_ctrl; sees only its ports.
module wpm_ctrl_properties import wpm_pkg::*; #(
	parameter int unsigned TICK_CYC = 20, // Cycles per tick
	parameter int unsigned OSC_START_CYC = 8 // Wake delay
) (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic ext_reset_i, // Reset pin
	input wire wpm_sfr_req_t sfr_i, // Register access
	input wire logic [7:0] sfr_rdata_o, // Read data
	input wire logic sfr_hit_o, // Address hit
	input wire logic irq_pending_i, // Interrupt
	input wire logic wake_irq_i, // Wake interrupt
	input wire wpm_gate_t gate_o, // Enables
	input wire logic chip_reset_o, // Reset request
	input wire logic [7:0] wd_count_o // Counter
);
	timeunit 1ns;
	timeprecision 100ps;
	// Slack of one register stage either side of the wake count
	localparam int WAKE_MIN = OSC_START_CYC - 2;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// ----
	// Properties
	// ----
	sequence s_wrap;
		wd_count_o == 8'hff && !sfr_i.wr ##1 wd_count_o == 8'h00;
	endsequence
	sequence s_wake;
		!gate_o.osc_run && wake_irq_i && !ext_reset_i ##1 !gate_o.cpu_clk_en;
	endsequence
	AST_HIT: assert property (sfr_hit_o == (sfr_i.addr inside {8'h87, 8'h92, 8'heb, 8'hff}))
		else $error("address hit wrong");
	AST_STANDBY_SELECT: assert property (sfr_i.wr && sfr_i.addr == 8'h92 && !ext_reset_i && !chip_reset_o
		|=> gate_o.analog_en != $past(sfr_i.wdata[0]))
		else $error("analog enable wrong");
	AST_STEP: assert property ($changed(wd_count_o) && !$past(sfr_i.wr) && !chip_reset_o
		&& !$past(chip_reset_o) |-> wd_count_o == $past(wd_count_o) + 8'h01)
		else $error("counter jumped");
	AST_WRAP: assert property (s_wrap |-> ##[0:1] chip_reset_o)
		else $error("no reset on overflow");
	AST_PULSE: assert property ($rose(chip_reset_o) && !ext_reset_i
		|-> ##23 chip_reset_o ##1 !chip_reset_o)
		else $error("reset pulse length wrong");
	AST_EXT: assert property (ext_reset_i [*3] |-> chip_reset_o)
		else $error("reset pin ignored");
	AST_IDLE: assert property (sfr_i.wr && sfr_i.addr == 8'h87 && sfr_i.wdata[1:0] == 2'b01
		&& gate_o.cpu_clk_en && !chip_reset_o && !ext_reset_i
		|=> !gate_o.cpu_clk_en && gate_o.periph_clk_en && gate_o.osc_run)
		else $error("idle gating wrong");
	AST_WAKE: assert property (s_wake |-> ##WAKE_MIN !gate_o.cpu_clk_en ##[1:3] gate_o.cpu_clk_en)
		else $error("wake delay wrong");
endmodule

bind wpm_ctrl wpm_ctrl_properties #(.TICK_CYC(TICK_CYC), .OSC_START_CYC(OSC_START_CYC))
	wpm_ctrl_properties_inst (.clk_i, .rst_i, .ext_reset_i, .sfr_i, .sfr_rdata_o, .sfr_hit_o,
	.irq_pending_i, .wake_irq_i, .gate_o, .chip_reset_o, .wd_count_o);

// File: tb/wpm_cpu_model.sv
// CPU core stand-in: one register access at a time on the sfr port.
// Assumes the bench calls it from one thread and keeps it quiet in idle.
module wpm_cpu_model import wpm_pkg::*; (
	input wire logic clk_i, // System clock
	input wire logic [7:0] rdata_i, // Read data
	output wpm_sfr_req_t sfr_o // Register access
);
	timeunit 1ns;
	timeprecision 100ps;
	initial sfr_o = '0;
	// Held through the taking edge; registered read data taken after it
	task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		@(posedge clk_i);
		#1 sfr_o = {w, !w, a, d};
		@(posedge clk_i);
		#1 sfr_o = '0;
		q = rdata_i;
	endtask
	// Software wait after standby exit, a little over 10 us
	task automatic settle;
		repeat (1002) @(posedge clk_i);
		#1;
	endtask
endmodule

// File: tb/tb_top.sv
// Bench for the watchdog and power mode controller, scenario by scenario.
// Assumes short tick and wake counts; the CPU model drives the sfr port.
module tb_top import wpm_pkg::*; ();
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TC = 20;
	localparam int OC = 8;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ext_reset_i = 1'b0;
	logic irq_pending_i = 1'b0;
	logic wake_irq_i = 1'b0;
	logic chip_reset;
	logic [7:0] rdata, cnt, q;
	wpm_sfr_req_t special_function_register;
	wpm_gate_t gate;
	int mismatches = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;

	wpm_ctrl #(.TICK_CYC(TC), .OSC_START_CYC(OC)) wpm_ctrl_inst (.clk_i, .rst_i, .ext_reset_i,
		.sfr_i(special_function_register), .sfr_rdata_o(rdata), .sfr_hit_o(), .irq_pending_i, .wake_irq_i,
		.gate_o(gate), .chip_reset_o(chip_reset), .wd_count_o(cnt));
	wpm_cpu_model wpm_cpu_model_inst (.clk_i, .rdata_i(rdata), .sfr_o(special_function_register));

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			give_verdict();
		end
	end

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		wpm_cpu_model_inst.acc(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, e);
		wpm_cpu_model_inst.acc(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask
	task automatic tk(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_regs;
		rd(8'heb, 8'h00);
		rd(8'h80, 8'h00);
		wr(8'h87, 8'hfc);
		rd(8'h87, 8'h1c);
		wr(8'h92, 8'hff);
		rd(8'h92, 8'h01);
		chk({gate.analog_en, gate.cpu_clk_en, gate.osc_run}, 8'h03);
		wr(8'h92, 8'h00);
		chk(gate.analog_ready, 1'b0);
		wpm_cpu_model_inst.settle();
		chk(gate.analog_ready, 1'b1);
	endtask
	task automatic t_reload;
		wr(8'hff, 8'hf0);
		chk(cnt, 8'hf0);
		rd(8'h87, 8'h0c);
		wr(8'hff, 8'h33);
		chk(cnt, 8'hf0);
	endtask
	task automatic t_wdog;
		wr(8'heb, 8'h02);
		wr(8'h87, 8'h10);
		wr(8'hff, 8'hfe);
		for (n = 0; n < 3 * TC && cnt == 8'hfe; n++) tk(1);
		chk(cnt, 8'hff);
		for (n = 0; n < 3 * TC && cnt == 8'hff; n++) tk(1);
		chk(8'(n), 8'(TC));
		for (n = 0; n < 4 && !chip_reset; n++) tk(1);
		for (n = 0; n < 40 && chip_reset; n++) tk(1);
		chk(8'(n), 8'h18);
		rd(8'heb, 8'h00);
	endtask
	task automatic t_idle;
		wr(8'heb, 8'h02);
		wr(8'h87, 8'h10);
		wr(8'hff, 8'h00);
		wr(8'h87, 8'h0d);
		chk({gate.cpu_clk_en, gate.periph_clk_en, gate.osc_run}, 8'h03);
		tk(3 * TC);
		chk(cnt > 8'h01, 1'b1);
		irq_pending_i = 1'b1;
		tk(2);
		irq_pending_i = 1'b0;
		chk(gate.cpu_clk_en, 1'b1);
		rd(8'h87, 8'h0c);
		wr(8'h87, 8'h02);
		chk(gate.osc_run, 1'b1);
		rd(8'h87, 8'h00);
		wr(8'heb, 8'h00);
	endtask
	task automatic t_pdown;
		wr(8'h87, 8'h06);
		chk({gate.cpu_clk_en, gate.osc_run}, 8'h00);
		irq_pending_i = 1'b1;
		tk(3);
		irq_pending_i = 1'b0;
		wake_irq_i = 1'b1;
		tk(1);
		wake_irq_i = 1'b0;
		chk({gate.cpu_clk_en, gate.osc_run}, 8'h01);
		for (n = 0; n < 4 * OC && !gate.cpu_clk_en; n++) tk(1);
		chk(8'(n), 8'(OC));
		rd(8'h87, 8'h04);
	endtask
	task automatic t_extrst(input logic [7:0] mode);
		wr(8'h87, mode);
		ext_reset_i = 1'b1;
		tk(1);
		ext_reset_i = 1'b0;
		tk(2);
		chk({chip_reset, gate.cpu_clk_en}, 8'h00);
		ext_reset_i = 1'b1;
		tk(3);
		chk(chip_reset, 1'b1);
		ext_reset_i = 1'b0;
		for (n = 0; n < 4 * OC && !gate.cpu_clk_en; n++) tk(1);
		chk(gate.cpu_clk_en, 1'b1);
		rd(8'h87, 8'h00);
	endtask

	initial begin
		repeat (6) @(posedge clk_i);
		#1 rst_i = 1'b0;
		t_regs();
		t_reload();
		t_wdog();
		t_idle();
		t_pdown();
		t_extrst(8'h01);
		t_extrst(8'h0a);
		give_verdict();
	end
endmodule
